// ===== verilog/rct_regs.sv
// Receiver calibration and crystal trim register bank with AXI4-Lite slave
// Function
// - Calibration runs crystal period times 80 times 7 times (N+4); default N is 7.
// - Filter bandwidth during calibration follows a 6-bit field, default code 04h.
// - Coarse trim capacitance equals the 5-bit code in 1 pF steps, reset 10h.
// - Coarse codes above 18h saturate to the 24 pF setting.
// - Four fine trim bits each connect their own capacitor; all reset clear.
// - Strength monitor pin buffer follows bit 0, reset enabled.
// - Converter input follows a 3-bit select, reset selects signal strength.
//
// Register access over AXI4-Lite is this design's own decision.
module rct_regs #(
  parameter int ADDR_W = 12,
  parameter int CAL_UNIT_P = rct_pkg::CAL_UNIT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] filter_cal_duration,
  output logic [5:0] filter_cal_bandwidth,
  output logic filter_cal_active,
  output logic [4:0] osc_coarse_cap,
  output logic osc_fine_cap_500ff,
  output logic osc_fine_cap_250ff,
  output logic osc_fine_cap_125ff,
  output logic osc_fine_cap_62ff,
  output logic strength_pin_buffer_en,
  output logic [2:0] converter_input_sel
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] cal_time;
    logic [5:0] cal_bw;
    logic [4:0] coarse_raw;
    logic [4:0] coarse_cap;
    logic [3:0] fine;
    logic mon_en;
    logic [2:0] adc_sel;
    logic cal_done;
    logic cal_start;
  } rct_state_t;

  localparam rct_state_t ST_RST = '{
    awready: 1'b1,
    wready: 1'b1,
    arready: 1'b1,
    bresp: rct_pkg::RESP_OKAY,
    rresp: rct_pkg::RESP_OKAY,
    cal_time: rct_pkg::CAL_TIME_RST,
    cal_bw: rct_pkg::CAL_BW_RST,
    coarse_raw: rct_pkg::COARSE_RST,
    coarse_cap: rct_pkg::COARSE_RST,
    fine: rct_pkg::FINE_RST,
    mon_en: rct_pkg::MON_EN_RST,
    adc_sel: rct_pkg::ADC_SEL_RST,
    default: '0
  };

  rct_state_t s_reg;
  rct_state_t s_next;
  logic cal_busy;
  logic cal_end;
  logic do_wr;
  logic wr_ok;
  logic [7:0] wr_idx;

  // Address bits above the index field must be zero for a hit
  function automatic logic in_range(input logic [ADDR_W-1:0] a);
    in_range = ((a >> 10) == '0);
  endfunction

  // Read decode: {response, data}; unused bits are simply never placed
  function automatic logic [33:0] rd_word(input logic [ADDR_W-1:0] a, input rct_state_t st,
                                          input logic busy);
    logic [7:0] idx;
    logic [31:0] d;
    logic [1:0] r;
    idx = a[9:2];
    d = 32'h0;
    r = rct_pkg::RESP_OKAY;
    if (!in_range(a))
      r = rct_pkg::RESP_SLVERR;
    else if (idx == rct_pkg::IDX_BPF_CAL_TIME)
      d[3:0] = st.cal_time;
    else if (idx == rct_pkg::IDX_BPF_CAL_BW)
      d[5:0] = st.cal_bw;
    else if (idx == rct_pkg::IDX_XTAL_COARSE)
      d[4:0] = st.coarse_raw;
    else if (idx == rct_pkg::IDX_XTAL_FINE)
      d[3:0] = st.fine;
    else if (idx == rct_pkg::IDX_SIGNAL_STRENGTH_MON)
      d[0] = st.mon_en;
    else if (idx == rct_pkg::IDX_ADC_SEL)
      d[2:0] = st.adc_sel;
    else if (idx == rct_pkg::IDX_CAL_CTRL)
    begin
      d[rct_pkg::STAT_BUSY_BIT] = busy;
      d[rct_pkg::STAT_DONE_BIT] = st.cal_done;
    end
    else
      r = rct_pkg::RESP_SLVERR;
    rd_word = {r, d};
  endfunction

  // Readback keeps the raw coarse code; only the pin value is clamped
  function automatic logic [4:0] sat_coarse(input logic [4:0] c);
    sat_coarse = (c > rct_pkg::COARSE_MAX) ? rct_pkg::COARSE_MAX : c;
  endfunction

  assign do_wr = s_reg.aw_got & s_reg.w_got & ~s_reg.bvalid;
  assign wr_ok = do_wr & s_reg.wstrb0 & in_range(s_reg.aw_addr);
  assign wr_idx = s_reg.aw_addr[9:2];

  always_comb
  begin
    logic [33:0] rw;
    logic hit;
    rw = 34'h0;
    hit = 1'b0;
    s_next = s_reg;
    s_next.cal_start = 1'b0;

    // Write address and data may come in either order
    if (s_axi_awvalid && s_reg.awready)
    begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
      s_next.awready = 1'b0;
    end
    if (s_axi_wvalid && s_reg.wready)
    begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata[7:0];
      s_next.wstrb0 = s_axi_wstrb[0];
      s_next.wready = 1'b0;
    end

    if (do_wr)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      if (in_range(s_reg.aw_addr))
      begin
        if (wr_idx == rct_pkg::IDX_BPF_CAL_TIME)
          hit = 1'b1;
        else if (wr_idx == rct_pkg::IDX_BPF_CAL_BW)
          hit = 1'b1;
        else if (wr_idx == rct_pkg::IDX_XTAL_COARSE)
          hit = 1'b1;
        else if (wr_idx == rct_pkg::IDX_XTAL_FINE)
          hit = 1'b1;
        else if (wr_idx == rct_pkg::IDX_SIGNAL_STRENGTH_MON)
          hit = 1'b1;
        else if (wr_idx == rct_pkg::IDX_ADC_SEL)
          hit = 1'b1;
        else if (wr_idx == rct_pkg::IDX_CAL_CTRL)
          hit = 1'b1;
      end
      s_next.bresp = hit ? rct_pkg::RESP_OKAY : rct_pkg::RESP_SLVERR;
    end

    // Only the low byte lane carries register bits
    if (wr_ok)
    begin
      if (wr_idx == rct_pkg::IDX_BPF_CAL_TIME)
        s_next.cal_time = s_reg.wdata[3:0];
      else if (wr_idx == rct_pkg::IDX_BPF_CAL_BW)
        s_next.cal_bw = s_reg.wdata[5:0];
      else if (wr_idx == rct_pkg::IDX_XTAL_COARSE)
      begin
        s_next.coarse_raw = s_reg.wdata[4:0];
        s_next.coarse_cap = sat_coarse(s_reg.wdata[4:0]);
      end
      else if (wr_idx == rct_pkg::IDX_XTAL_FINE)
        s_next.fine = s_reg.wdata[3:0];
      else if (wr_idx == rct_pkg::IDX_SIGNAL_STRENGTH_MON)
        s_next.mon_en = s_reg.wdata[0];
      else if (wr_idx == rct_pkg::IDX_ADC_SEL)
        s_next.adc_sel = s_reg.wdata[2:0];
      else if (wr_idx == rct_pkg::IDX_CAL_CTRL)
      begin
        s_next.cal_start = s_reg.wdata[rct_pkg::CTRL_START_BIT];
        if (s_reg.wdata[rct_pkg::CTRL_CLEAR_BIT])
          s_next.cal_done = 1'b0;
      end
    end

    // A calibration ending in the same cycle as a clear still leaves done set
    if (cal_end)
      s_next.cal_done = 1'b1;

    if (s_reg.bvalid && s_axi_bready)
    begin
      s_next.bvalid = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
    end

    if (s_axi_arvalid && s_reg.arready)
    begin
      rw = rd_word(s_axi_araddr, s_reg, cal_busy);
      s_next.rresp = rw[33:32];
      s_next.rdata = rw[31:0];
      s_next.rvalid = 1'b1;
      s_next.arready = 1'b0;
    end
    else if (s_reg.rvalid && s_axi_rready)
    begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_reg <= ST_RST;
    else
      s_reg <= s_next;
  end

  rct_cal_timer #(
    .UNIT_CYCLES(CAL_UNIT_P)
  ) u_cal_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(s_reg.cal_start),
    .duration(s_reg.cal_time),
    .busy(cal_busy),
    .done(cal_end)
  );

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign filter_cal_duration = s_reg.cal_time;
  assign filter_cal_bandwidth = s_reg.cal_bw;
  assign filter_cal_active = cal_busy;
  assign osc_coarse_cap = s_reg.coarse_cap;
  assign osc_fine_cap_500ff = s_reg.fine[3];
  assign osc_fine_cap_250ff = s_reg.fine[2];
  assign osc_fine_cap_125ff = s_reg.fine[1];
  assign osc_fine_cap_62ff = s_reg.fine[0];
  assign strength_pin_buffer_en = s_reg.mon_en;
  assign converter_input_sel = s_reg.adc_sel;

  bandwidth_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ok && wr_idx == rct_pkg::IDX_BPF_CAL_BW |=> filter_cal_bandwidth == $past(s_reg.wdata[5:0]))
    else $error("bandwidth does not follow write");

  coarse_clamp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ok && wr_idx == rct_pkg::IDX_XTAL_COARSE && s_reg.wdata[4:0] > rct_pkg::COARSE_MAX
    |=> osc_coarse_cap == rct_pkg::COARSE_MAX)
    else $error("coarse trim not clamped");

  coarse_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ok && wr_idx == rct_pkg::IDX_XTAL_COARSE && s_reg.wdata[4:0] <= rct_pkg::COARSE_MAX
    |=> osc_coarse_cap == $past(s_reg.wdata[4:0]))
    else $error("coarse trim does not follow write");

  coarse_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    osc_coarse_cap <= rct_pkg::COARSE_MAX)
    else $error("coarse trim above maximum");

  fine_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ok && wr_idx == rct_pkg::IDX_XTAL_FINE |=> {osc_fine_cap_500ff, osc_fine_cap_250ff,
    osc_fine_cap_125ff, osc_fine_cap_62ff} == $past(s_reg.wdata[3:0]))
    else $error("fine trim bits do not follow write");

  monitor_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ok && wr_idx == rct_pkg::IDX_SIGNAL_STRENGTH_MON |=> strength_pin_buffer_en == $past(s_reg.wdata[0]))
    else $error("monitor buffer enable does not follow bit 0");

  input_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ok && wr_idx == rct_pkg::IDX_ADC_SEL |=> converter_input_sel == $past(s_reg.wdata[2:0]))
    else $error("converter select does not follow write");

  duration_cfg_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ok && wr_idx == rct_pkg::IDX_BPF_CAL_TIME |=> filter_cal_duration == $past(s_reg.wdata[3:0]))
    else $error("calibration time field does not follow write");

  unused_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
    else $error("unused read bits not zero");

  coarse_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && in_range(s_axi_araddr) &&
    s_axi_araddr[9:2] == rct_pkg::IDX_XTAL_COARSE |=> s_axi_rdata[7:5] == 3'h0)
    else $error("coarse register unused bits read nonzero");

  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr |=> s_axi_bvalid)
    else $error("write response not raised after write");

endmodule // rct_regs

// ===== inc/rct_pkg.sv
// Constants shared by the receiver calibration and trim register bank
package rct_pkg;

  // Register indices; the byte address of each register is four times its index
  localparam logic [7:0] IDX_BPF_CAL_TIME = 8'h8A;
  localparam logic [7:0] IDX_BPF_CAL_BW = 8'h8B;
  localparam logic [7:0] IDX_XTAL_COARSE = 8'h8C;
  localparam logic [7:0] IDX_XTAL_FINE = 8'h8D;
  localparam logic [7:0] IDX_SIGNAL_STRENGTH_MON = 8'h8E;
  localparam logic [7:0] IDX_ADC_SEL = 8'h8F;
  localparam logic [7:0] IDX_CAL_CTRL = 8'hC0;

  // Field widths
  localparam int CAL_TIME_W = 4;
  localparam int CAL_BW_W = 6;
  localparam int COARSE_W = 5;
  localparam int FINE_W = 4;
  localparam int ADC_SEL_W = 3;

  // Reset values
  localparam logic [3:0] CAL_TIME_RST = 4'h7;
  localparam logic [5:0] CAL_BW_RST = 6'h04;
  localparam logic [4:0] COARSE_RST = 5'h10;
  localparam logic [3:0] FINE_RST = 4'h0;
  localparam logic MON_EN_RST = 1'b1;
  localparam logic [2:0] ADC_SEL_RST = 3'h0;

  // Documented bandwidth codes
  localparam logic [5:0] BW_50K = 6'h04;
  localparam logic [5:0] BW_80K = 6'h0D;
  localparam logic [5:0] BW_125K = 6'h16;
  localparam logic [5:0] BW_200K = 6'h1F;
  localparam logic [5:0] BW_300K = 6'h27;

  // Converter input selections
  localparam logic [2:0] ADC_SIGNAL_STRENGTH = 3'h0;
  localparam logic [2:0] ADC_TEMPERATURE = 3'h1;
  localparam logic [2:0] ADC_HALF_DIGITAL_SUPPLY = 3'h2;

  // Coarse trim ceiling, code 18h is 24 pF
  localparam logic [4:0] COARSE_MAX = 5'h18;

  // Control register bit positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // Calibration time in crystal periods: 80 * 7 * (N + 4)
  localparam int CLK_HZ = 20000000;
  localparam int XTAL_PERIOD_NS = 50;
  localparam int XTAL_CYCLES = (XTAL_PERIOD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int CAL_BASE = 80;
  localparam int CAL_STEP = 7;
  localparam int CAL_OFFSET = 4;
  localparam int CAL_UNIT_CYCLES = XTAL_CYCLES * CAL_BASE * CAL_STEP;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== verilog/rct_cal_timer.sv
// Band-pass filter calibration duration timer
module rct_cal_timer #(
  parameter int UNIT_CYCLES = rct_pkg::CAL_UNIT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [3:0] duration,
  output logic busy,
  output logic done
);

  localparam int UW = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;

  typedef struct packed {
    logic busy;
    logic done;
    logic [3:0] n;
    logic [UW-1:0] unit_cnt;
    logic [4:0] step_cnt;
  } rct_tmr_t;

  rct_tmr_t s_reg;
  rct_tmr_t s_next;
  logic [4:0] last_step;

  assign last_step = 5'(s_reg.n) + 5'(rct_pkg::CAL_OFFSET - 1);

  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    // A start while running is ignored so the duration cannot be cut short
    if (start && !s_reg.busy)
    begin
      s_next.busy = 1'b1;
      s_next.n = duration;
      s_next.unit_cnt = '0;
      s_next.step_cnt = '0;
    end
    else if (s_reg.busy)
    begin
      if (s_reg.unit_cnt == UW'(UNIT_CYCLES - 1))
      begin
        s_next.unit_cnt = '0;
        if (s_reg.step_cnt == last_step)
        begin
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
        end
        else
        begin
          s_next.step_cnt = s_reg.step_cnt + 5'h01;
        end
      end
      else
      begin
        s_next.unit_cnt = s_reg.unit_cnt + UW'(1);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign busy = s_reg.busy;
  assign done = s_reg.done;

  // Cycles spent busy, for checking only
  logic [31:0] elapsed;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      elapsed <= 32'h0;
    else if (s_reg.busy)
      elapsed <= elapsed + 32'h1;
    else if (start)
      elapsed <= 32'h0;
  end

  cal_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(s_reg.busy) |-> (elapsed == UNIT_CYCLES * (32'(s_reg.n) + 32'(rct_pkg::CAL_OFFSET))))
    else $error("calibration length wrong");

  done_after_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(s_reg.busy) |-> s_reg.done)
    else $error("done pulse missing at end of calibration");

endmodule // rct_cal_timer

// ===== sim/tb_top.sv
// Self-checking testbench for the calibration and trim register bank
`define CHECK(got, exp) \
  begin checks++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Short calibration unit keeps the longest run under a hundred cycles
  localparam int UNIT = 4;
  localparam logic [7:0] REG_IDX [6] = '{rct_pkg::IDX_BPF_CAL_TIME, rct_pkg::IDX_BPF_CAL_BW,
    rct_pkg::IDX_XTAL_COARSE, rct_pkg::IDX_XTAL_FINE, rct_pkg::IDX_SIGNAL_STRENGTH_MON, rct_pkg::IDX_ADC_SEL};
  localparam logic [7:0] RST_VAL [6] = '{8'h07, 8'h04, 8'h10, 8'h00, 8'h01, 8'h00};
  localparam logic [7:0] USED_MASK [6] = '{8'h0F, 8'h3F, 8'h1F, 8'h0F, 8'h01, 8'h07};
  localparam logic [5:0] BW_CODES [5] = '{rct_pkg::BW_50K, rct_pkg::BW_80K, rct_pkg::BW_125K,
    rct_pkg::BW_200K, rct_pkg::BW_300K};
  localparam logic [4:0] COARSE_IN [6] = '{5'h00, 5'h01, 5'h17, 5'h18, 5'h19, 5'h1F};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [3:0] filter_cal_duration;
  logic [5:0] filter_cal_bandwidth;
  logic filter_cal_active;
  logic [4:0] osc_coarse_cap;
  logic osc_fine_cap_500ff;
  logic osc_fine_cap_250ff;
  logic osc_fine_cap_125ff;
  logic osc_fine_cap_62ff;
  logic strength_pin_buffer_en;
  logic [2:0] converter_input_sel;
  logic [3:0] fine_bits;
  int fails = 0;
  int checks = 0;
  int act_cnt = 0;

  assign fine_bits = {osc_fine_cap_500ff, osc_fine_cap_250ff, osc_fine_cap_125ff,
    osc_fine_cap_62ff};

  always #25 aclk = ~aclk;

  always @(posedge aclk)
    if (filter_cal_active === 1'b1)
      act_cnt <= act_cnt + 1;

  rct_regs #(.ADDR_W(12), .CAL_UNIT_P(UNIT)) rct_regs_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .filter_cal_duration(filter_cal_duration), .filter_cal_bandwidth(filter_cal_bandwidth),
    .filter_cal_active(filter_cal_active), .osc_coarse_cap(osc_coarse_cap),
    .osc_fine_cap_500ff(osc_fine_cap_500ff), .osc_fine_cap_250ff(osc_fine_cap_250ff),
    .osc_fine_cap_125ff(osc_fine_cap_125ff), .osc_fine_cap_62ff(osc_fine_cap_62ff),
    .strength_pin_buffer_en(strength_pin_buffer_en), .converter_input_sel(converter_input_sel));

  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic bus_wait_check(input int n);
    if (n >= 50)
    begin
      fails++;
      $display("wrong value at %0t: bus handshake timed out", $time);
    end
  endtask

  // Address and data are offered together; each is dropped once its own ready is seen
  task automatic axi_write(input logic [7:0] idx, input logic [31:0] data, input logic [3:0] strb,
    input logic [1:0] exp_resp);
    int n;
    logic aw_done;
    logic w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= data;
    s_axi_wstrb <= strb;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done) && n < 50)
    begin
      @(posedge aclk);
      n++;
      if (!aw_done && s_axi_awready === 1'b1)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    bus_wait_check(n);
    `CHECK(s_axi_bresp, exp_resp)
    // Idle edge so a following call never reassigns bready in this time step
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [7:0] idx, input logic [31:0] exp_data,
    input logic [1:0] exp_resp);
    int n;
    n = 0;
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (s_axi_arready !== 1'b1 && n < 50);
    s_axi_arvalid <= 1'b0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    bus_wait_check(n);
    `CHECK(s_axi_rdata, exp_data)
    `CHECK(s_axi_rresp, exp_resp)
    // Idle edge so a following call never reassigns rready in this time step
    @(posedge aclk);
  endtask

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic test_reset_values;
    for (int i = 0; i < 6; i++)
      axi_read(REG_IDX[i], {24'h0, RST_VAL[i]}, rct_pkg::RESP_OKAY);
    `CHECK(filter_cal_duration, 4'h7)
    `CHECK(filter_cal_bandwidth, 6'h04)
    `CHECK(osc_coarse_cap, 5'h10)
    `CHECK(fine_bits, 4'h0)
    `CHECK(strength_pin_buffer_en, 1'b1)
    `CHECK(converter_input_sel, 3'h0)
    `CHECK(filter_cal_active, 1'b0)
    $display("test reset_values done, fails %0d", fails);
  endtask

  task automatic test_unused_bits;
    for (int i = 0; i < 6; i++)
    begin
      axi_write(REG_IDX[i], 32'hFFFFFFFF, 4'hF, rct_pkg::RESP_OKAY);
      axi_read(REG_IDX[i], {24'h0, USED_MASK[i]}, rct_pkg::RESP_OKAY);
    end
    `CHECK(filter_cal_bandwidth, 6'h3F)
    `CHECK(osc_coarse_cap, rct_pkg::COARSE_MAX)
    `CHECK(fine_bits, 4'hF)
    `CHECK(converter_input_sel, 3'h7)
    $display("test unused_bits done, fails %0d", fails);
  endtask

  task automatic test_field_codes;
    for (int i = 0; i < 5; i++)
    begin
      axi_write(rct_pkg::IDX_BPF_CAL_BW, {26'h0, BW_CODES[i]}, 4'hF, rct_pkg::RESP_OKAY);
      `CHECK(filter_cal_bandwidth, BW_CODES[i])
    end
    // Readback keeps the raw code; only the capacitor output saturates
    for (int i = 0; i < 6; i++)
    begin
      axi_write(rct_pkg::IDX_XTAL_COARSE, {27'h0, COARSE_IN[i]}, 4'hF, rct_pkg::RESP_OKAY);
      `CHECK(osc_coarse_cap, (COARSE_IN[i] > 5'h18) ? 5'h18 : COARSE_IN[i])
      axi_read(rct_pkg::IDX_XTAL_COARSE, {27'h0, COARSE_IN[i]}, rct_pkg::RESP_OKAY);
    end
    for (int i = 0; i < 4; i++)
    begin
      axi_write(rct_pkg::IDX_XTAL_FINE, 32'h1 << i, 4'hF, rct_pkg::RESP_OKAY);
      `CHECK(fine_bits, 4'h1 << i)
    end
    for (int i = 0; i < 2; i++)
    begin
      axi_write(rct_pkg::IDX_SIGNAL_STRENGTH_MON, 32'hFE + i, 4'hF, rct_pkg::RESP_OKAY);
      `CHECK(strength_pin_buffer_en, i[0])
    end
    for (int i = 0; i < 3; i++)
    begin
      axi_write(rct_pkg::IDX_ADC_SEL, 32'hF8 + i, 4'hF, rct_pkg::RESP_OKAY);
      `CHECK(converter_input_sel, i[2:0])
    end
    $display("test field_codes done, fails %0d", fails);
  endtask

  // A new duration written mid-run must not stretch the running calibration
  task automatic test_calibration(input logic [3:0] n);
    axi_write(rct_pkg::IDX_BPF_CAL_TIME, {28'h0, n}, 4'hF, rct_pkg::RESP_OKAY);
    `CHECK(filter_cal_duration, n)
    act_cnt = 0;
    axi_write(rct_pkg::IDX_CAL_CTRL, 32'h1, 4'hF, rct_pkg::RESP_OKAY);
    axi_write(rct_pkg::IDX_BPF_CAL_TIME, {28'h0, ~n}, 4'hF, rct_pkg::RESP_OKAY);
    // A second start while running must neither restart nor stretch the run
    axi_write(rct_pkg::IDX_CAL_CTRL, 32'h1, 4'hF, rct_pkg::RESP_OKAY);
    axi_read(rct_pkg::IDX_CAL_CTRL, 32'h1, rct_pkg::RESP_OKAY);
    repeat (UNIT * (n + 4) + 20) @(posedge aclk);
    `CHECK(act_cnt, UNIT * (n + 4))
    axi_read(rct_pkg::IDX_CAL_CTRL, 32'h2, rct_pkg::RESP_OKAY);
    axi_write(rct_pkg::IDX_CAL_CTRL, 32'h2, 4'hF, rct_pkg::RESP_OKAY);
    axi_read(rct_pkg::IDX_CAL_CTRL, 32'h0, rct_pkg::RESP_OKAY);
    $display("test calibration n=%0d done, fails %0d", n, fails);
  endtask

  task automatic test_bus_errors;
    axi_write(8'h90, 32'hFF, 4'hF, rct_pkg::RESP_SLVERR);
    axi_read(8'h90, 32'h0, rct_pkg::RESP_SLVERR);
    axi_write(rct_pkg::IDX_XTAL_COARSE, 32'h05, 4'hF, rct_pkg::RESP_OKAY);
    axi_write(rct_pkg::IDX_XTAL_COARSE, 32'h0A, 4'h0, rct_pkg::RESP_OKAY);
    `CHECK(osc_coarse_cap, 5'h05)
    $display("test bus_errors done, fails %0d", fails);
  endtask

  initial
  begin
    repeat (5000) @(posedge aclk);
    fails++;
    $display("wrong value at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial
  begin
    do_reset();
    test_reset_values();
    test_unused_bits();
    test_field_codes();
    test_calibration(4'h0);
    test_calibration(4'hF);
    test_bus_errors();
    do_reset();
    test_reset_values();
    report_and_stop();
  end
endmodule // tb_top
